//--- awd_pkg.sv
// Constants, register map and carrier types for the analogue window watchdog
package awd_pkg;
  localparam int CLK_MHZ         = 40;
  localparam int PROG_CYCLE_NS   = 10000;
  localparam int PROG_CYCLE_CLKS = (PROG_CYCLE_NS * CLK_MHZ) / 1000;
  localparam int TICK_W          = $clog2(PROG_CYCLE_CLKS);

  localparam int AIN_COUNT  = 8;
  localparam int AIN_W      = 10;
  localparam int AIN_FULL   = 1000;
  localparam int GAIN_SCALE = 100;
  localparam int GAIN_MAX   = 1000;
  localparam int OFFSET_MAX = 10000;
  localparam int DELTA_MAX  = 20000;
  localparam int MARGIN_MAX = 20000;
  localparam int DEC_MAX    = 3;

  localparam logic [3:0] SEL_AQ1 = 4'h8;
  localparam logic [3:0] SEL_AQ2 = 4'h9;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GAIN   = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_DELTA  = 8'h0C;
  localparam logic [7:0] ADDR_UPPER  = 8'h10;
  localparam logic [7:0] ADDR_LOWER  = 8'h14;
  localparam logic [7:0] ADDR_DEC    = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_REF    = 8'h20;
  localparam logic [7:0] ADDR_LIVE   = 8'h24;

  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_DELTA    = 4;
  localparam int CTRL_UP_EXT   = 5;
  localparam int CTRL_LO_EXT   = 6;
  localparam int STAT_ARMED    = 0;
  localparam int STAT_ALARM    = 1;

  typedef logic signed [15:0]             awd_val_t;
  typedef logic [AIN_W-1:0]               awd_ain_t;
  typedef logic [AIN_COUNT-1:0][AIN_W-1:0] awd_ain_bus_t;

  typedef struct packed {
    logic [3:0] sel;
    logic       use_delta;
    logic       upper_ext;
    logic       lower_ext;
    awd_val_t   gain;
    awd_val_t   offset;
    awd_val_t   delta;
    awd_val_t   upper;
    awd_val_t   lower;
    logic [1:0] dec;
  } awd_cfg_t;

  localparam awd_cfg_t CFG_RESET = '{sel: 4'h0, use_delta: 1'b1, upper_ext: 1'b0,
                                     lower_ext: 1'b0, gain: 16'sh0064, offset: 16'sh0000,
                                     delta: 16'sh0000, upper: 16'sh0000, lower: 16'sh0000,
                                     dec: 2'h0};
endpackage : awd_pkg

//--- awd_chan_sel.sv
// Source selector for the monitored analogue signal
`timescale 1ns/1ps
`default_nettype none
module awd_chan_sel
  import awd_pkg::*;
(
  input  wire awd_pkg::awd_ain_bus_t i_analog_inputs,
  input  wire awd_pkg::awd_ain_t     i_analog_output_one,
  input  wire awd_pkg::awd_ain_t     i_analog_output_two,
  input  wire logic [3:0]            i_sel,
  output var awd_pkg::awd_val_t      o_monitored_signal
);
  awd_ain_t pick;

  always_comb begin
    if (i_sel == SEL_AQ1) begin
      pick = i_analog_output_one;
    end else if (i_sel == SEL_AQ2) begin
      pick = i_analog_output_two;
    end else if (i_sel < SEL_AQ1) begin
      pick = i_analog_inputs[i_sel[2:0]];
    end else begin
      pick = '0;
    end
    // Full scale is 10 V; anything above the span is pinned to it
    if (int'(pick) > AIN_FULL) begin
      o_monitored_signal = awd_val_t'(AIN_FULL);
    end else begin
      o_monitored_signal = awd_val_t'({6'h00, pick});
    end
  end
endmodule : awd_chan_sel
`default_nettype wire

//--- awd_scale.sv
// Gain and offset scaling of one internal analogue value
`timescale 1ns/1ps
`default_nettype none
module awd_scale
  import awd_pkg::*;
(
  input  wire awd_pkg::awd_val_t i_raw,
  input  wire awd_pkg::awd_val_t i_gain,
  input  wire awd_pkg::awd_val_t i_offset,
  output logic signed [31:0]     o_scaled
);
  logic signed [31:0] prod;

  // Gain is held in hundredths, so the product is divided back down
  always_comb begin
    prod     = 32'(i_raw) * 32'(i_gain);
    o_scaled = (prod / GAIN_SCALE) + 32'(i_offset);
  end
endmodule : awd_scale
`default_nettype wire

//--- awd_watchdog.sv
// Analogue window watchdog with APB register access
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - Rising edge of arm input stores current sample as reference, starts monitoring
// RULE2 - Monitored source selectable among eight inputs and two outputs, 0..1000
// RULE3 - Gain accepted within +-10.00, offset within +-10000
// RULE4 - Live sample and reference both scaled by gain then offset before compare
// RULE5 - Signed delta within +-20000 sets band distance around reference
// RULE6 - Upper and lower margins 0..20000 set band above and below reference
// RULE7 - Decimal places 0..3 are display only, never touch comparisons
// RULE8 - Output high while armed and scaled live value outside the band
// RULE9 - Output low when value returns inside band or arm input drops
// RULE10 - Both margins may come from another block's live value
// RULE11 - Band edges count as inside; evaluated once per program cycle
module awd_watchdog
  import awd_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  i_arm,
  input  wire awd_pkg::awd_ain_bus_t i_analog_inputs,
  input  wire awd_pkg::awd_ain_t     i_analog_output_one,
  input  wire awd_pkg::awd_ain_t     i_analog_output_two,
  input  wire awd_pkg::awd_val_t     i_upper_ext,
  input  wire awd_pkg::awd_val_t     i_lower_ext,
  output logic                       o_alarm,
  output logic                       o_armed,
  output logic                       o_cycle
);
  import awd_pkg::*;

  awd_cfg_t           cfg;
  awd_val_t           ref_raw;
  awd_val_t           live_raw;
  logic signed [31:0] live_scaled;
  logic signed [31:0] ref_scaled;
  logic signed [31:0] ref_now;
  logic signed [31:0] upper_margin;
  logic signed [31:0] lower_margin;
  logic signed [31:0] band_hi;
  logic signed [31:0] band_lo;
  logic signed [31:0] live_hold;
  logic signed [31:0] ref_hold;
  logic [TICK_W-1:0]  tick_cnt;
  logic               tick;
  logic               arm_prev;
  logic               arm_rise;
  logic               outside;
  logic               access;
  logic               wr_en;
  logic [31:0]        next_prdata;
  logic               next_err;

  // Clamp a signed word into a documented parameter range
  function automatic awd_val_t sat(input logic signed [31:0] v,
                                   input int lo,
                                   input int hi);
    if (v > hi) begin
      sat = awd_val_t'(hi);
    end else if (v < lo) begin
      sat = awd_val_t'(lo);
    end else begin
      sat = awd_val_t'(v);
    end
  endfunction : sat

  // Sign extension of a scaled value for register read back
  function automatic logic [31:0] word(input logic signed [31:0] v);
    word = 32'(v);
  endfunction : word

  // Absolute value, used where a signed delta gives a symmetric band
  function automatic logic signed [31:0] mag(input logic signed [31:0] v);
    mag = (v < 0) ? -v : v;
  endfunction : mag

  // External margins are saturated, since another block may deliver any value
  function automatic logic signed [31:0] margin(input logic     ext_en,
                                                input awd_val_t ext_val,
                                                input awd_val_t own_val);
    if (ext_en) begin
      margin = 32'(sat(32'(ext_val), 0, MARGIN_MAX));
    end else begin
      margin = 32'(own_val);
    end
  endfunction : margin

  // Status and snapshot words sit at the top of the map and are read only
  function automatic logic read_only(input logic [7:0] a);
    read_only = (a >= ADDR_STATUS);
  endfunction : read_only

  // Source pick, pinned to full scale
  awd_chan_sel u_sel (
    .i_analog_inputs     (i_analog_inputs),
    .i_analog_output_one (i_analog_output_one),
    .i_analog_output_two (i_analog_output_two),
    .i_sel               (cfg.sel),
    .o_monitored_signal  (live_raw)
  ); // RULE2

  awd_scale u_live_scale (
    .i_raw    (live_raw),
    .i_gain   (cfg.gain),
    .i_offset (cfg.offset),
    .o_scaled (live_scaled)
  ); // RULE4

  awd_scale u_ref_scale (
    .i_raw    (ref_raw),
    .i_gain   (cfg.gain),
    .i_offset (cfg.offset),
    .o_scaled (ref_scaled)
  ); // RULE4

  // Program cycle divider
  // Inputs are looked at only on its tick, as in a relay scan; a dropped arm input acts at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign tick = (tick_cnt == TICK_W'(PROG_CYCLE_CLKS - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cycle <= 1'b0;
    end else begin
      o_cycle <= tick;
    end
  end

  // A rising arm input is only looked at on program cycle boundaries
  // A pulse that spans no tick is therefore missed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      arm_prev <= 1'b0;
    end else if (tick) begin
      arm_prev <= i_arm;
    end
  end

  assign arm_rise = tick && i_arm && !arm_prev; // RULE1

  // Reference kept raw, so a later gain or offset change rescales it too
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_raw <= '0;
    end else if (arm_rise) begin
      ref_raw <= live_raw; // RULE1
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_armed <= 1'b0;
    end else if (!i_arm) begin
      o_armed <= 1'b0;
    end else if (arm_rise) begin
      o_armed <= 1'b1; // RULE1
    end
  end

  // On the edge cycle the freshly stored sample is the reference
  assign ref_now = arm_rise ? live_scaled : ref_scaled;

  // Margins from another block are used as delivered, limited to range
  always_comb begin
    if (cfg.use_delta) begin
      upper_margin = mag(32'(cfg.delta)); // RULE5
      lower_margin = mag(32'(cfg.delta)); // RULE5
    end else begin
      upper_margin = margin(cfg.upper_ext, i_upper_ext, cfg.upper); // RULE10 RULE6
      lower_margin = margin(cfg.lower_ext, i_lower_ext, cfg.lower); // RULE10 RULE6
    end
    band_hi = ref_now + upper_margin;
    band_lo = ref_now - lower_margin;
  end

  // Equality with an edge is still inside
  assign outside = (live_scaled > band_hi) || (live_scaled < band_lo); // RULE11

  // Alarm holds between ticks; only a dropped arm input cuts it short
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alarm <= 1'b0;
    end else if (!i_arm) begin
      o_alarm <= 1'b0; // RULE9
    end else if (tick) begin
      o_alarm <= outside && (o_armed || arm_rise); // RULE8 RULE9 RULE11
    end
  end

  // Values snapshotted per cycle so software sees what was compared
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      live_hold <= '0;
    end else if (tick) begin
      live_hold <= live_scaled;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_hold <= '0;
    end else if (tick) begin
      ref_hold <= ref_now;
    end
  end

  // APB: one wait state so read data leaves a flip-flop
  // The !pready term stops one request from being answered twice
  assign access = psel && penable && !pready;
  // A write lands at the edge where the master sees pready high
  assign wr_en  = psel && penable && pready && pwrite;

  // pready is a one-cycle pulse, one clock after the access is taken
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg <= CFG_RESET;
    end else if (wr_en && !read_only(paddr)) begin
      // Out-of-range values are saturated rather than refused
      unique case (paddr)
        ADDR_CTRL: begin
          cfg.sel       <= pwdata[CTRL_SEL_LSB +: 4]; // RULE2
          cfg.use_delta <= pwdata[CTRL_DELTA];
          cfg.upper_ext <= pwdata[CTRL_UP_EXT]; // RULE10
          cfg.lower_ext <= pwdata[CTRL_LO_EXT]; // RULE10
        end
        ADDR_GAIN: begin
          cfg.gain <= sat(pwdata, -GAIN_MAX, GAIN_MAX); // RULE3
        end
        ADDR_OFFSET: begin
          cfg.offset <= sat(pwdata, -OFFSET_MAX, OFFSET_MAX); // RULE3
        end
        ADDR_DELTA: begin
          cfg.delta <= sat(pwdata, -DELTA_MAX, DELTA_MAX); // RULE5
        end
        ADDR_UPPER: begin
          cfg.upper <= sat(pwdata, 0, MARGIN_MAX); // RULE6
        end
        ADDR_LOWER: begin
          cfg.lower <= sat(pwdata, 0, MARGIN_MAX); // RULE6
        end
        ADDR_DEC: begin
          // Display only; nothing in the comparison reads it
          cfg.dec <= 2'(sat(pwdata, 0, DEC_MAX)); // RULE7
        end
        default: begin
        end
      endcase
    end
  end

  // Unmapped addresses read zero and raise the error flag
  always_comb begin
    next_prdata = '0;
    next_err    = 1'b0;
    unique case (paddr)
      ADDR_CTRL: begin
        next_prdata[CTRL_SEL_LSB +: 4] = cfg.sel;
        next_prdata[CTRL_DELTA]        = cfg.use_delta;
        next_prdata[CTRL_UP_EXT]       = cfg.upper_ext;
        next_prdata[CTRL_LO_EXT]       = cfg.lower_ext;
      end
      ADDR_GAIN: begin
        next_prdata = word(32'(cfg.gain));
      end
      ADDR_OFFSET: begin
        next_prdata = word(32'(cfg.offset));
      end
      ADDR_DELTA: begin
        next_prdata = word(32'(cfg.delta));
      end
      ADDR_UPPER: begin
        next_prdata = word(32'(cfg.upper));
      end
      ADDR_LOWER: begin
        next_prdata = word(32'(cfg.lower));
      end
      ADDR_DEC: begin
        next_prdata[1:0] = cfg.dec;
      end
      ADDR_STATUS: begin
        next_prdata[STAT_ARMED] = o_armed;
        next_prdata[STAT_ALARM] = o_alarm;
      end
      ADDR_REF: begin
        next_prdata = word(ref_hold);
      end
      ADDR_LIVE: begin
        next_prdata = word(live_hold);
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // Read data holds until the next access, so a slow master still sees it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata <= '0;
    end else if (access) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  // Error flag stands only beside pready
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pslverr <= 1'b0;
    end else if (access) begin
      pslverr <= next_err || (pwrite && read_only(paddr));
    end else begin
      pslverr <= 1'b0;
    end
  end
endmodule : awd_watchdog
`default_nettype wire

//--- awd_watchdog_sva.sv
// Port-level checks for the analogue window watchdog
`timescale 1ns/1ps
`default_nettype none
module awd_watchdog_sva
  import awd_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        i_arm,
  input wire logic        o_alarm,
  input wire logic        o_armed,
  input wire logic        o_cycle
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [9:0] gap;
  logic       seen;
  // First pulse after reset has no earlier pulse to measure from
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gap  <= '0;
      seen <= 1'b0;
    end else if (o_cycle) begin
      gap  <= '0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 10'h001;
    end
  end
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_data: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("bad error read");
  a_alarm_armed: assert property (o_alarm |-> o_armed) else $error("alarm while idle");
  a_disarm_clear: assert property (!i_arm |=> !o_alarm && !o_armed) else $error("disarm ignored");
  a_arm_edge: assert property ($rose(o_armed) |-> $past(i_arm)) else $error("armed without input");
  a_alarm_tick: assert property ($rose(o_alarm) |-> ##[0:1] o_cycle) else $error("alarm off tick");
  a_cycle_gap: assert property (o_cycle && seen |-> gap == 10'(PROG_CYCLE_CLKS - 1)) else $error("bad cycle");
  cover property ($rose(o_alarm));
  cover property ($fell(o_alarm) && i_arm);
  cover property (pslverr);
endmodule : awd_watchdog_sva
`default_nettype wire

//--- awd_src_model.sv
// Analogue source model: input channels, output readbacks, external margins
`timescale 1ns/1ps
`default_nettype none
module awd_src_model
  import awd_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic [9:0]           i_level,
  input  wire awd_pkg::awd_val_t    i_up,
  input  wire awd_pkg::awd_val_t    i_lo,
  output var awd_pkg::awd_ain_bus_t o_analog_inputs,
  output var awd_pkg::awd_ain_t     o_analog_output_one,
  output var awd_pkg::awd_ain_t     o_analog_output_two,
  output var awd_pkg::awd_val_t     o_upper_ext,
  output var awd_pkg::awd_val_t     o_lower_ext
);
  // Channel k carries level plus k, so a wrong selection shows
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < AIN_COUNT; k++) begin
      o_analog_inputs[k] <= i_level + 10'(k);
    end
    o_analog_output_one <= i_level + 10'h008;
    o_analog_output_two <= i_level + 10'h009;
    o_upper_ext         <= i_up;
    o_lower_ext         <= i_lo;
  end
endmodule : awd_src_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the analogue window watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
  import awd_pkg::*;
  logic         i_clk, i_rst, psel, penable, pwrite, pready, pslverr, i_arm, o_alarm, o_armed, o_cycle;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, seed;
  logic [9:0]   level;
  awd_val_t     eu, el, up_ext, lo_ext;
  awd_ain_bus_t ain;
  awd_ain_t     aq1, aq2;
  int           n_errors, num_checks, cyc, g, o;

  always #12.5 i_clk = ~i_clk;

  awd_src_model i_awd_src_model (.i_clk, .i_level(level), .i_up(eu), .i_lo(el), .o_analog_inputs(ain),
    .o_analog_output_one(aq1), .o_analog_output_two(aq2), .o_upper_ext(up_ext), .o_lower_ext(lo_ext));
  awd_watchdog i_awd_watchdog (.i_clk, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .i_arm, .i_analog_inputs(ain), .i_analog_output_one(aq1), .i_analog_output_two(aq2),
    .i_upper_ext(up_ext), .i_lower_ext(lo_ext), .o_alarm, .o_armed, .o_cycle);

  function automatic int rnd(int n);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed % n);
  endfunction : rnd
  function automatic int st(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction : st
  function automatic int sc(int s, int lv);
    return (s < 10 ? st(lv + s, 0, AIN_FULL) : 0) * g / 100 + o;
  endfunction : sc

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] xd, logic xe);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    if (!w) chk(prdata, xd);
    chk(32'(pslverr), 32'(xe));
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : xfer

  // Two pulses guarantee one full sample after the last input change
  task automatic tk;
    repeat (2) begin
      do @(posedge i_clk); while (o_cycle !== 1'b1);
    end
  endtask : tk

  task automatic run(int s, int d, int m, int u, int l, int x, int lr, int lv);
    int rf, lvv, hi, lw, al;
    eu    <= awd_val_t'(rnd(65536));
    el    <= awd_val_t'(rnd(65536));
    level <= 10'(lr);
    xfer(1, ADDR_CTRL, 32'(s + 16 * m + 32 * x), 0, 0);
    xfer(1, ADDR_GAIN, 32'(g), 0, 0);
    xfer(1, ADDR_OFFSET, 32'(o), 0, 0);
    xfer(1, ADDR_DELTA, 32'(d), 0, 0);
    xfer(1, ADDR_UPPER, 32'(u), 0, 0);
    xfer(1, ADDR_LOWER, 32'(l), 0, 0);
    xfer(1, ADDR_DEC, 32'(rnd(4)), 0, 0);
    tk;
    i_arm <= 1'b1;
    tk;
    chk(32'(o_armed), 1);
    level <= 10'(lv);
    tk;
    rf  = sc(s, lr);
    lvv = sc(s, lv);
    hi  = rf + (m ? (d < 0 ? -d : d) : (x[0] ? st(eu, 0, 20000) : u));
    lw  = rf - (m ? (d < 0 ? -d : d) : (x[1] ? st(el, 0, 20000) : l));
    al  = int'(lvv > hi || lvv < lw);
    chk(32'(o_alarm), 32'(al));
    xfer(0, ADDR_REF, 0, 32'(rf), 0);
    xfer(0, ADDR_LIVE, 0, 32'(lvv), 0);
    xfer(0, ADDR_STATUS, 0, 32'(2 * al + 1), 0);
    level <= 10'(lr);
    tk;
    chk(32'(o_alarm), 0);
    i_arm <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(32'({o_alarm, o_armed}), 0);
    $display("Run sel %0d mode %0d done", s, m);
  endtask : run

  task automatic final_report;
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      final_report;
    end
  end

  initial begin
    i_clk   = 1'b0;
    i_rst   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    i_arm   = 1'b0;
    level   = 10'h000;
    eu      = 16'sh0000;
    el      = 16'sh0000;
    seed    = 32'h78C49F49;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    xfer(0, ADDR_CTRL, 0, 32'h10, 0);
    xfer(0, ADDR_GAIN, 0, 32'h64, 0);
    for (int a = 8; a < 40; a += 4) xfer(0, 8'(a), 0, 0, 0);
    xfer(0, 8'h28, 0, 0, 1);
    xfer(1, ADDR_STATUS, 32'h3, 0, 1);
    xfer(1, ADDR_GAIN, 32'hFFFFF830, 0, 0);
    xfer(0, ADDR_GAIN, 0, 32'hFFFFFC18, 0);
    xfer(1, ADDR_OFFSET, 32'h00004E20, 0, 0);
    xfer(0, ADDR_OFFSET, 0, 32'h00002710, 0);
    xfer(1, ADDR_DELTA, 32'hFFFF8AD0, 0, 0);
    xfer(0, ADDR_DELTA, 0, 32'hFFFFB1E0, 0);
    xfer(1, ADDR_LOWER, 32'h00007530, 0, 0);
    xfer(0, ADDR_LOWER, 0, 32'h00004E20, 0);
    xfer(1, ADDR_DEC, 32'h7, 0, 0);
    xfer(0, ADDR_DEC, 0, 32'h3, 0);
    $display("Register map test done");
    g = 100;
    o = 0;
    run(0, 5, 1, 0, 0, 0, 500, 505);
    run(0, -5, 1, 0, 0, 0, 500, 494);
    run(9, 0, 0, 5, 3, 0, 500, 506);
    run(8, 0, 0, 5, 3, 0, 500, 497);
    run(3, 0, 0, 0, 0, 3, 400, 420);
    run(5, 0, 0, 10, 10, 0, 1010, 980);
    for (int i = 0; i < 14; i++) begin
      g = rnd(2001) - 1000;
      o = rnd(20001) - 10000;
      run(rnd(16), rnd(40001) - 20000, rnd(2), rnd(20001), rnd(20001), rnd(4), rnd(990), rnd(990));
    end
    final_report;
  end
endmodule : tb

bind awd_watchdog awd_watchdog_sva i_awd_watchdog_sva (.i_clk, .i_rst, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .i_arm, .o_alarm, .o_armed, .o_cycle);
`default_nettype wire
